// *** design/ocr_output_state_regs.sv ***
// Purpose: Output stage configuration registers for clock and SYSREF outs
// Assumes: Serial front end delivers byte reads and writes on one clock
// Notes: Outputs are registered copies of the effective settings
`timescale 1ns/1ps

module ocr_output_state_regs (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  output ocr_pkg::ocr_clk_cfg_t [ocr_pkg::NCLK-1:0] CLK_OUT_CFG,
  output ocr_pkg::ocr_sref_cfg_t [ocr_pkg::NSREF-1:0] SREF_OUT_CFG
);

  // ==========================================================
  // Helpers

  // Finds a SYSREF register slot; bit 3 flags a hit
  function automatic logic [3:0] sref_find(
    input logic [7:0] a,
    input logic drv
  );
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < ocr_pkg::NSREF; i++) begin
      if (a == (drv ? ocr_pkg::SREF_DRV_ADDR[i]
                    : ocr_pkg::SREF_DLY_ADDR[i])) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  // Total SYSREF delay in ps from coarse and fine codes
  function automatic logic [10:0] delay_of(
    input logic [2:0] c,
    input logic [2:0] f
  );
    logic [10:0] d;
    d = 11'(11'(c) * ocr_pkg::COARSE_STEP_PS);
    return 11'(d + ocr_pkg::FINE_PS[f]);
  endfunction

  // ==========================================================
  // Storage
  logic [7:0] sref_dly_ff [ocr_pkg::NSREF];
  logic [7:0] sref_drv_ff [ocr_pkg::NSREF];
  logic [7:0] sref_en_ff;
  logic [3:0] clk_cfg_ff [ocr_pkg::NCLK];

  // ==========================================================
  // Address decode
  logic [3:0] dly_find;
  logic [3:0] drv_find;
  logic en_hit;
  logic clk_hit;
  logic [3:0] clk_idx;
  logic [7:0] clk_off;

  assign dly_find = sref_find(REG_ADDR, 1'b0);
  assign drv_find = sref_find(REG_ADDR, 1'b1);
  assign en_hit = (REG_ADDR == ocr_pkg::SREF_EN_ADDR);
  assign clk_off = 8'(REG_ADDR - ocr_pkg::CLK_CFG_BASE);
  // Ten consecutive clock output slots
  assign clk_hit = (REG_ADDR >= ocr_pkg::CLK_CFG_BASE) &&
                   (clk_off < 8'(ocr_pkg::NCLK));
  assign clk_idx = clk_off[3:0];

  // ==========================================================
  // SYSREF delay and source registers
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < ocr_pkg::NSREF; i++) begin
        sref_dly_ff[i] <= ocr_pkg::DLY_RESET;
      end
    end else if (REG_WR && dly_find[3]) begin
      // Reserved D7 stays zero
      sref_dly_ff[dly_find[2:0]] <= REG_WDATA & ocr_pkg::DLY_MASK;
    end
  end

  // SYSREF drive registers
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < ocr_pkg::NSREF; i++) begin
        sref_drv_ff[i] <= ocr_pkg::DRV_RESET;
      end
    end else if (REG_WR && drv_find[3]) begin
      // Reserved D6, D1 and D0 stay zero
      sref_drv_ff[drv_find[2:0]] <= REG_WDATA & ocr_pkg::DRV_MASK;
    end
  end

  // Shared SYSREF enable register
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sref_en_ff <= ocr_pkg::EN_RESET;
    end else if (REG_WR && en_hit) begin
      sref_en_ff <= REG_WDATA;
    end
  end

  // Device clock output registers
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < ocr_pkg::NCLK; i++) begin
        clk_cfg_ff[i] <= ocr_pkg::CC_RESET[3:0];
      end
    end else if (REG_WR && clk_hit) begin
      clk_cfg_ff[clk_idx] <= REG_WDATA[3:0];
    end
  end

  // ==========================================================
  // Read path
  logic [7:0] nxt_rdata;

  // Unmapped offsets read zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (dly_find[3]) begin
      nxt_rdata = sref_dly_ff[dly_find[2:0]];
    end else if (drv_find[3]) begin
      nxt_rdata = sref_drv_ff[drv_find[2:0]];
    end else if (en_hit) begin
      nxt_rdata = sref_en_ff;
    end else if (clk_hit) begin
      nxt_rdata = {4'h0, clk_cfg_ff[clk_idx]};
    end
  end

  // Read data lands one cycle after the strobe
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      REG_RDATA <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= nxt_rdata;
      end
    end
  end

  // ==========================================================
  // Effective device clock settings
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      CLK_OUT_CFG <= '0;
    end else begin
      for (int i = 0; i < ocr_pkg::NCLK; i++) begin
        CLK_OUT_CFG[i].swing <=
          clk_cfg_ff[i][ocr_pkg::CC_SWING_LSB +: 2];
        CLK_OUT_CFG[i].fmt <= clk_cfg_ff[i][ocr_pkg::CC_FMT];
        CLK_OUT_CFG[i].en <= clk_cfg_ff[i][ocr_pkg::CC_EN];
      end
    end
  end

  // Effective SYSREF settings; power-down forces format, swing and enable off, bias passes through
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      SREF_OUT_CFG <= '0;
    end else begin
      for (int i = 0; i < ocr_pkg::NSREF; i++) begin : g_sref
        logic pd;
        logic [2:0] cr;
        logic [2:0] fn;
        pd = sref_drv_ff[i][ocr_pkg::DRV_PD];
        cr = sref_dly_ff[i][ocr_pkg::DLY_COARSE_LSB +: 3];
        fn = {sref_dly_ff[i][ocr_pkg::DLY_FINE_HI],
              sref_dly_ff[i][ocr_pkg::DLY_FINE_LSB +: 2]};
        SREF_OUT_CFG[i].pd <= pd;
        SREF_OUT_CFG[i].bias <= sref_drv_ff[i][ocr_pkg::DRV_BIAS];
        SREF_OUT_CFG[i].fmt <= !pd &&
          sref_drv_ff[i][ocr_pkg::DRV_FMT];
        SREF_OUT_CFG[i].swing <= pd ? 2'b00 :
          sref_drv_ff[i][ocr_pkg::DRV_SWING_LSB +: 2];
        // A0 sits at the top bit of the shared enable register
        SREF_OUT_CFG[i].en <= !pd &&
          sref_en_ff[ocr_pkg::NSREF-1-i];
        SREF_OUT_CFG[i].src <= sref_dly_ff[i][ocr_pkg::DLY_SRC];
        SREF_OUT_CFG[i].coarse <= cr;
        SREF_OUT_CFG[i].fine <= fn;
        SREF_OUT_CFG[i].delay_ps <= delay_of(cr, fn);
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  clk_swing_write_a: assert property (
    REG_WR && REG_ADDR == ocr_pkg::CLK_CFG_BASE |-> ##2
    CLK_OUT_CFG[0].swing == $past(REG_WDATA[3:2], 2))
    else $error("clock swing not taken from write");

  clk_format_last_a: assert property (
    REG_WR && REG_ADDR == 8'(ocr_pkg::CLK_CFG_BASE + 8'd9) |-> ##2
    CLK_OUT_CFG[9].fmt == $past(REG_WDATA[1], 2))
    else $error("last clock format not taken from write");

  clk_enable_write_a: assert property (
    REG_WR && REG_ADDR == ocr_pkg::CLK_CFG_BASE |-> ##2
    CLK_OUT_CFG[0].en == $past(REG_WDATA[0], 2))
    else $error("clock enable not taken from write");

  sref_source_d_a: assert property (
    REG_WR && REG_ADDR == ocr_pkg::SREF_DLY_ADDR[7] |-> ##2
    SREF_OUT_CFG[7].src == $past(REG_WDATA[4], 2) &&
    SREF_OUT_CFG[7].coarse == $past(REG_WDATA[3:1], 2))
    else $error("SYSREF source or coarse not taken");

  sref_pd_write_a: assert property (
    REG_WR && REG_ADDR == ocr_pkg::SREF_DRV_ADDR[0] |-> ##2
    SREF_OUT_CFG[0].pd == $past(REG_WDATA[7], 2))
    else $error("SYSREF power-down not taken");

  sref_enable_order_a: assert property (
    REG_WR && REG_ADDR == ocr_pkg::SREF_EN_ADDR |-> ##2
    SREF_OUT_CFG[7].en == ($past(REG_WDATA[0], 2) &&
                           !SREF_OUT_CFG[7].pd))
    else $error("SYSREF enable bit order wrong");

  sref_delay_range_a: assert property (
    SREF_OUT_CFG[0].delay_ps >=
      11'(11'(SREF_OUT_CFG[0].coarse) * ocr_pkg::COARSE_STEP_PS) &&
    SREF_OUT_CFG[0].delay_ps <=
      11'(11'(SREF_OUT_CFG[0].coarse) * ocr_pkg::COARSE_STEP_PS +
          ocr_pkg::FINE_MAX_PS))
    else $error("SYSREF delay outside coarse step window");

  sref_pd_mask_a: assert property (
    SREF_OUT_CFG[3].pd |->
    !SREF_OUT_CFG[3].en && !SREF_OUT_CFG[3].fmt &&
    SREF_OUT_CFG[3].swing == 2'b00)
    else $error("powered-down SYSREF output still driven");

  sref_reserved_zero_a: assert property (
    REG_RD && REG_ADDR == ocr_pkg::SREF_DRV_ADDR[0] |=>
    REG_RVALID && REG_RDATA[6] == 1'b0 && REG_RDATA[1:0] == 2'b00)
    else $error("reserved SYSREF bits read non-zero");

  clk_enable_cov: cover property (
    REG_WR && clk_hit ##2 CLK_OUT_CFG[0].en);
  sref_pd_cov: cover property (SREF_OUT_CFG[0].pd);
  sref_max_delay_cov: cover property (
    SREF_OUT_CFG[7].coarse == 3'h7 && SREF_OUT_CFG[7].fine == 3'h7);

endmodule // ocr_output_state_regs

// *** design/ocr_pkg.sv ***
// Purpose: Constants and carrier types for the output state register bank
// Assumes: Byte-wide register port in front of the bank
// Notes: Clock output config offsets are local placements
package ocr_pkg;

  localparam int NCLK = 10;
  localparam int NSREF = 8;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] SREF_DLY_ADDR [NSREF] = '{
    8'h28, 8'h29, 8'h2A, 8'h38, 8'h39, 8'h48, 8'h49, 8'h58};
  localparam logic [7:0] SREF_DRV_ADDR [NSREF] = '{
    8'h2C, 8'h2D, 8'h2E, 8'h3C, 8'h3D, 8'h4C, 8'h4D, 8'h5C};
  localparam logic [7:0] SREF_EN_ADDR = 8'h76;
  localparam logic [7:0] CLK_CFG_BASE = 8'h60;

  // ==========================================================
  // Field positions
  localparam int DLY_FINE_HI = 0;
  localparam int DLY_COARSE_LSB = 1;
  localparam int DLY_SRC = 4;
  localparam int DLY_FINE_LSB = 5;
  localparam int DRV_SWING_LSB = 2;
  localparam int DRV_FMT = 4;
  localparam int DRV_BIAS = 5;
  localparam int DRV_PD = 7;
  localparam int CC_EN = 0;
  localparam int CC_FMT = 1;
  localparam int CC_SWING_LSB = 2;

  // ==========================================================
  // Writable masks and reset values
  localparam logic [7:0] DLY_MASK = 8'h7F;
  localparam logic [7:0] DRV_MASK = 8'hBC;
  localparam logic [7:0] CC_MASK = 8'h0F;
  localparam logic [7:0] DLY_RESET = 8'h10;
  localparam logic [7:0] DRV_RESET = 8'h00;
  localparam logic [7:0] EN_RESET = 8'h00;
  localparam logic [7:0] CC_RESET = 8'h00;

  // ==========================================================
  // Delay figures in ps
  localparam logic [10:0] COARSE_STEP_PS = 11'd169;
  localparam logic [10:0] FINE_PS [8] = '{
    11'd0, 11'd25, 11'd50, 11'd75, 11'd85, 11'd110, 11'd135, 11'd160};
  localparam logic [10:0] FINE_MAX_PS = 11'd160;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [1:0] swing;
    logic fmt;
    logic en;
  } ocr_clk_cfg_t;

  typedef struct packed {
    logic pd;
    logic bias;
    logic fmt;
    logic [1:0] swing;
    logic en;
    logic src;
    logic [2:0] coarse;
    logic [2:0] fine;
    logic [10:0] delay_ps;
  } ocr_sref_cfg_t;

endpackage

// *** bench/output_state_config_regs_test.sv ***
// Purpose: Self-checking bench for the output state register bank
// Assumes: Byte reads answer one cycle later, config lands two cycles later
// Notes: Reads are queued by the driver and checked by the monitor
`timescale 1ns/1ps

module output_state_config_regs_test;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [7:0] REG_WDATA = 8'h00;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [7:0] REG_RDATA;
  logic REG_RVALID;
  ocr_pkg::ocr_clk_cfg_t [ocr_pkg::NCLK-1:0] clk_cfg;
  ocr_pkg::ocr_sref_cfg_t [ocr_pkg::NSREF-1:0] sref_cfg;
  int bad_count = 0;
  int n_compared = 0;
  logic [7:0] exp_mem [256];
  logic [7:0] rd_q [$];
  logic [7:0] addrs [$];
  logic [7:0] lfsr = 8'h59;
  localparam logic [10:0] FINE_TAB [8] = '{11'h000, 11'h019, 11'h032,
    11'h04B, 11'h055, 11'h06E, 11'h087, 11'h0A0};

  // ==========================================================
  // Clock and device
  always #5 CLK = ~CLK;

  ocr_output_state_regs dut (.CLK(CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .CLK_OUT_CFG(clk_cfg), .SREF_OUT_CFG(sref_cfg));

  // ==========================================================
  // Helpers
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Writable bits of each address, zero where nothing is mapped
  function automatic logic [7:0] mask_of(input logic [7:0] a);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < ocr_pkg::NSREF; i++) begin
      if (a == ocr_pkg::SREF_DLY_ADDR[i]) m = 8'h7F;
      if (a == ocr_pkg::SREF_DRV_ADDR[i]) m = 8'hBC;
    end
    for (int i = 0; i < ocr_pkg::NCLK; i++) begin
      if (a == 8'(ocr_pkg::CLK_CFG_BASE + i)) m = 8'h0F;
    end
    if (a == 8'h76) m = 8'hFF;
    return m;
  endfunction

  task automatic chk(input string what, input logic [31:0] e, g);
    n_compared++;
    if (e !== g) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One access per falling edge; a read notes the old stored value
  task automatic acc(input logic wr, rd, input logic [7:0] a, d);
    @(negedge CLK);
    REG_WR = wr;
    REG_RD = rd;
    REG_ADDR = a;
    REG_WDATA = d;
    if (rd) rd_q.push_back(exp_mem[a]);
    if (wr) exp_mem[a] = d & mask_of(a);
  endtask

  task automatic idle;
    @(negedge CLK);
    REG_WR = 1'b0;
    REG_RD = 1'b0;
  endtask

  task automatic read_all;
    foreach (addrs[k]) acc(1'b0, 1'b1, addrs[k], 8'h00);
    acc(1'b0, 1'b1, 8'h01, 8'h00);
    acc(1'b0, 1'b1, 8'hFF, 8'h00);
    idle();
    for (int n = 0; n < 8 && rd_q.size() != 0; n++) @(posedge CLK);
    if (rd_q.size() != 0) chk("read_drain", 32'h0, 32'(rd_q.size()));
  endtask

  task automatic reset_all;
    @(negedge CLK);
    RST_B = 1'b0;
    repeat (4) @(negedge CLK);
    foreach (exp_mem[i]) exp_mem[i] = 8'h00;
    foreach (ocr_pkg::SREF_DLY_ADDR[i]) exp_mem[ocr_pkg::SREF_DLY_ADDR[i]] = 8'h10;
    RST_B = 1'b1;
    @(posedge CLK);
    #1;
  endtask

  // Expected output fields built from the stored register model
  task automatic check_cfg;
    ocr_pkg::ocr_sref_cfg_t s;
    logic [7:0] d;
    logic [7:0] v;
    for (int i = 0; i < ocr_pkg::NCLK; i++) begin
      d = exp_mem[8'(ocr_pkg::CLK_CFG_BASE + i)];
      chk("clk_cfg", 32'(d[3:0]), 32'(clk_cfg[i]));
    end
    for (int j = 0; j < ocr_pkg::NSREF; j++) begin
      d = exp_mem[ocr_pkg::SREF_DLY_ADDR[j]];
      v = exp_mem[ocr_pkg::SREF_DRV_ADDR[j]];
      s.pd = v[7];
      s.bias = v[5];
      s.fmt = v[4] & ~v[7];
      s.swing = v[3:2] & {2{~v[7]}};
      s.en = exp_mem[8'h76][7-j] & ~v[7];
      s.src = d[4];
      s.coarse = d[3:1];
      s.fine = {d[0], d[6:5]};
      s.delay_ps = 11'(s.coarse) * 11'd169 + FINE_TAB[s.fine];
      chk("sref_cfg", 32'(s), 32'(sref_cfg[j]));
    end
  endtask

  // ==========================================================
  // Monitor: each read answer takes the oldest note
  always @(posedge CLK) begin
    if (REG_RVALID === 1'b1) begin
      if (rd_q.size() == 0) chk("rvalid_extra", 32'h0, 32'h1);
      else chk("reg_rdata", 32'(rd_q.pop_front()), 32'(REG_RDATA));
    end
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge CLK);
    chk("watchdog", 32'h0, 32'h1);
    summarize();
  end

  // ==========================================================
  // Main sequence
  initial begin
    foreach (ocr_pkg::SREF_DLY_ADDR[i]) addrs.push_back(ocr_pkg::SREF_DLY_ADDR[i]);
    foreach (ocr_pkg::SREF_DRV_ADDR[i]) addrs.push_back(ocr_pkg::SREF_DRV_ADDR[i]);
    addrs.push_back(8'h76);
    for (int i = 0; i < ocr_pkg::NCLK; i++) addrs.push_back(8'(ocr_pkg::CLK_CFG_BASE + i));
    reset_all();
    check_cfg();
    read_all();
    $display("test reset_values done");
    // All ones, then random rounds; round one also reads while writing
    for (int r = 0; r < 4; r++) begin
      foreach (addrs[k]) begin
        lfsr = lfsr_next(lfsr);
        acc(1'b1, r == 1, addrs[k], (r == 0) ? 8'hFF : lfsr);
      end
      acc(1'b1, 1'b0, 8'h01, 8'hFF);
      idle();
      repeat (2) @(posedge CLK);
      #1;
      check_cfg();
      read_all();
      $display("test write_round %0d done", r);
    end
    reset_all();
    check_cfg();
    read_all();
    $display("test mid_run_reset done");
    summarize();
  end
endmodule // output_state_config_regs_test
